// *** lane_alarm_trim_defines.vh ***
`ifndef LANE_ALARM_TRIM_DEFINES_VH
`define LANE_ALARM_TRIM_DEFINES_VH

// Register indices as printed; byte address is four times the index
`define IDX_LANE_FIFO_ERROR_FLAGS 12'h2c4
`define IDX_EVENT_STATUS 12'h2c1
`define IDX_EVENT_MASK 12'h2c2
`define IDX_CORE_A_DUAL_TRIM 12'h310
`define IDX_CORE_B_DUAL_TRIM 12'h313
`define IDX_CORE_A_SGL_IN1_TRIM 12'h314
`define IDX_CORE_B_SGL_IN1_TRIM 12'h315
`define IDX_CORE_A_SGL_IN2_TRIM 12'h31a
`define IDX_MODE_CTRL 12'h3f0
`define IDX_IRQ_STATUS 12'h3f4
`define IDX_IRQ_ENABLE 12'h3f5
`define IDX_IRQ_CLEAR 12'h3f6

`define LANE_COUNT 16
`define LANE_FLAGS_RESET 16'hffff
`define SUMMARY_BIT 5
`define SUMMARY_RESET 1'h1
`define SUMMARY_MASK_RESET 1'h1
`define TRIM_WIDTH 8
`define TRIM_COUNT 5

// Mode control fields
`define MODE_SINGLE_BIT 0
`define MODE_FGCAL_BIT 1
`define MODE_INPUT_TWO_BIT 2

// Interrupt status layout
`define IRQ_LANE_EVENT_BIT 0
`define IRQ_GLOBAL_ALARM_BIT 1
`define IRQ_WIDTH 2

`endif

// *** lane_fifo_alarm_and_timing_trim_regs.v ***
// Our own choice: register access over Wishbone.
`timescale 1ns/1ns
`include "lane_alarm_trim_defines.vh"

module lane_fifo_alarm_and_timing_trim_regs (
  input wire sys_clk,
  input wire rst_n,
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire wb_we_i,
  input wire [13:0] wb_adr_i,
  input wire [3:0] wb_sel_i,
  input wire [31:0] wb_dat_i,
  output reg [31:0] wb_dat_o,
  output reg wb_ack_o,
  input wire [15:0] laneFifoFault,
  input wire [7:0] fuseCoreADual,
  input wire [7:0] fuseCoreBDual,
  input wire [7:0] fuseCoreASingleIn1,
  input wire [7:0] fuseCoreBSingleIn1,
  input wire [7:0] fuseCoreASingleIn2,
  output reg [7:0] coreATrim,
  output reg [7:0] coreBTrim,
  output reg globalAlarm,
  output reg irq
);

  localparam LOAD_FUSE = 1'b0;
  localparam RUN = 1'b1;

  function [7:0] pickTrim;
    input [7:0] sel;
    input [7:0] alt;
    input useSel;
    begin
      pickTrim = useSel ? sel : alt;
    end
  endfunction

  // Fault inputs come from the lane clock domain
  reg [15:0] faultMeta_reg;
  reg [15:0] faultSync2_reg;
  reg [15:0] faultSync3_reg;
  reg [15:0] faultLevel_reg;
  reg [15:0] laneFlags_reg;
  reg [15:0] laneFlags_next;
  reg summary_reg;
  reg summary_next;
  reg summaryMask_reg;
  reg [5:0] statusOther_reg;
  reg [5:0] maskOther_reg;
  reg [7:0] trimADual_reg;
  reg [7:0] trimBDual_reg;
  reg [7:0] trimASgl1_reg;
  reg [7:0] trimBSgl1_reg;
  reg [7:0] trimASgl2_reg;
  reg [2:0] modeCtrl_reg;
  reg [1:0] irqStatus_reg;
  reg [1:0] irqStatus_next;
  reg [1:0] irqEnable_reg;
  reg state_reg;
  reg [31:0] readData;
  reg globalPrev_reg;

  wire [11:0] regIdx = wb_adr_i[13:2];
  wire access = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  wire wrLo = access & wb_we_i & wb_sel_i[0];
  wire wrHi = access & wb_we_i & wb_sel_i[1];
  wire wrLane = regIdx == `IDX_LANE_FIFO_ERROR_FLAGS;
  wire wrStatus = wrLo & (regIdx == `IDX_EVENT_STATUS);
  wire summaryClr = wrStatus & wb_dat_i[`SUMMARY_BIT];
  wire [15:0] laneClr = {{8{wrHi & wrLane}}, {8{wrLo & wrLane}}} & wb_dat_i[15:0];
  wire [15:0] faultAgreed = ~(faultSync2_reg ^ faultSync3_reg);
  wire [15:0] faultNow = (faultAgreed & faultSync3_reg) | (~faultAgreed & faultLevel_reg);
  wire laneEvent = |faultNow;
  wire globalNow = (summary_reg & ~summaryMask_reg) | |(statusOther_reg & ~maskOther_reg);

  always @(posedge sys_clk) begin
    faultMeta_reg <= laneFifoFault;
    faultSync2_reg <= faultMeta_reg;
    faultSync3_reg <= faultSync2_reg;
    if (!rst_n) begin
      faultLevel_reg <= 16'h0000;
    end else begin
      faultLevel_reg <= faultNow;
    end
  end

  always @* begin
    // Clears apply first so a live fault re-sets the flag in the same edge
    laneFlags_next = laneFlags_reg & ~laneClr;
    if (summaryClr) begin
      laneFlags_next = 16'h0000;
    end
    laneFlags_next = laneFlags_next | faultNow;
    summary_next = (summary_reg & ~summaryClr) | laneEvent;
    irqStatus_next = irqStatus_reg;
    if (access & wb_we_i & wb_sel_i[0] & (regIdx == `IDX_IRQ_CLEAR)) begin
      irqStatus_next = irqStatus_reg & ~wb_dat_i[1:0];
    end
    irqStatus_next[`IRQ_LANE_EVENT_BIT] = irqStatus_next[`IRQ_LANE_EVENT_BIT] | laneEvent;
    irqStatus_next[`IRQ_GLOBAL_ALARM_BIT] = irqStatus_next[`IRQ_GLOBAL_ALARM_BIT] |
      (globalNow & ~globalPrev_reg);
  end

  always @(posedge sys_clk) begin
    if (!rst_n) begin
      laneFlags_reg <= `LANE_FLAGS_RESET;
      summary_reg <= `SUMMARY_RESET;
      statusOther_reg <= 6'h1f;
      summaryMask_reg <= `SUMMARY_MASK_RESET;
      maskOther_reg <= 6'h1f;
      irqStatus_reg <= 2'h0;
      irqEnable_reg <= 2'h0;
      modeCtrl_reg <= 3'h0;
      globalPrev_reg <= 1'b0;
      state_reg <= LOAD_FUSE;
      trimADual_reg <= 8'h00;
      trimBDual_reg <= 8'h00;
      trimASgl1_reg <= 8'h00;
      trimBSgl1_reg <= 8'h00;
      trimASgl2_reg <= 8'h00;
    end else begin
      laneFlags_reg <= laneFlags_next;
      summary_reg <= summary_next;
      irqStatus_reg <= irqStatus_next;
      globalPrev_reg <= globalNow;
      if (wrStatus) begin
        // Other alarm sources live elsewhere; only their clear is kept here
        statusOther_reg <= statusOther_reg & ~{1'b0, wb_dat_i[4:0]};
      end
      case (state_reg)
        LOAD_FUSE: begin
          // Fuse values captured on the first edge after reset release
          trimADual_reg <= fuseCoreADual;
          trimBDual_reg <= fuseCoreBDual;
          trimASgl1_reg <= fuseCoreASingleIn1;
          trimBSgl1_reg <= fuseCoreBSingleIn1;
          trimASgl2_reg <= fuseCoreASingleIn2;
          state_reg <= RUN;
        end
        RUN: begin
          if (wrLo) begin
            case (regIdx)
              `IDX_CORE_A_DUAL_TRIM: trimADual_reg <= wb_dat_i[7:0];
              `IDX_CORE_B_DUAL_TRIM: trimBDual_reg <= wb_dat_i[7:0];
              `IDX_CORE_A_SGL_IN1_TRIM: trimASgl1_reg <= wb_dat_i[7:0];
              `IDX_CORE_B_SGL_IN1_TRIM: trimBSgl1_reg <= wb_dat_i[7:0];
              `IDX_CORE_A_SGL_IN2_TRIM: trimASgl2_reg <= wb_dat_i[7:0];
              `IDX_EVENT_MASK: begin
                summaryMask_reg <= wb_dat_i[`SUMMARY_BIT];
                maskOther_reg <= {1'b0, wb_dat_i[4:0]};
              end
              `IDX_MODE_CTRL: modeCtrl_reg <= wb_dat_i[2:0];
              `IDX_IRQ_ENABLE: irqEnable_reg <= wb_dat_i[1:0];
              default: begin
              end
            endcase
          end
        end
        default: state_reg <= LOAD_FUSE;
      endcase
    end
  end

  always @* begin
    readData = 32'h00000000;
    case (regIdx)
      `IDX_LANE_FIFO_ERROR_FLAGS: readData[15:0] = laneFlags_reg;
      `IDX_EVENT_STATUS: readData[5:0] = {summary_reg, statusOther_reg[4:0]};
      `IDX_EVENT_MASK: readData[5:0] = {summaryMask_reg, maskOther_reg[4:0]};
      `IDX_CORE_A_DUAL_TRIM: readData[7:0] = trimADual_reg;
      `IDX_CORE_B_DUAL_TRIM: readData[7:0] = trimBDual_reg;
      `IDX_CORE_A_SGL_IN1_TRIM: readData[7:0] = trimASgl1_reg;
      `IDX_CORE_B_SGL_IN1_TRIM: readData[7:0] = trimBSgl1_reg;
      `IDX_CORE_A_SGL_IN2_TRIM: readData[7:0] = trimASgl2_reg;
      `IDX_MODE_CTRL: readData[2:0] = modeCtrl_reg;
      `IDX_IRQ_STATUS: readData[1:0] = irqStatus_reg;
      `IDX_IRQ_ENABLE: readData[1:0] = irqEnable_reg;
      default: readData = 32'h00000000;
    endcase
  end

  // Every access is acknowledged one cycle later; unmapped reads return zero
  always @(posedge sys_clk) begin
    if (!rst_n) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h00000000;
      coreATrim <= 8'h00;
      coreBTrim <= 8'h00;
      globalAlarm <= 1'b0;
      irq <= 1'b0;
    end else begin
      wb_ack_o <= access;
      wb_dat_o <= access ? readData : 32'h00000000;
      // Dual mode uses the dual trims; single mode picks by input and cal
      if (!modeCtrl_reg[`MODE_SINGLE_BIT]) begin
        coreATrim <= trimADual_reg;
        coreBTrim <= trimBDual_reg;
      end else if (modeCtrl_reg[`MODE_INPUT_TWO_BIT]) begin
        coreATrim <= trimASgl2_reg;
        coreBTrim <= trimBDual_reg;
      end else begin
        coreATrim <= pickTrim(trimASgl1_reg, trimADual_reg,
          modeCtrl_reg[`MODE_FGCAL_BIT]);
        coreBTrim <= pickTrim(trimBSgl1_reg, trimBDual_reg,
          modeCtrl_reg[`MODE_FGCAL_BIT]);
      end
      globalAlarm <= globalNow;
      irq <= |(irqStatus_next & irqEnable_reg);
    end
  end

endmodule // lane_fifo_alarm_and_timing_trim_regs

// *** lane_alarm_trim_props.sv ***
`timescale 1ns/1ns
module lane_alarm_trim_chk (
  input wire sys_clk,
  input wire rst_n,
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire wb_we_i,
  input wire [13:0] wb_adr_i,
  input wire [31:0] wb_dat_o,
  input wire wb_ack_o
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  chk_ack_answer: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("request not answered next cycle");
  chk_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  chk_ack_cause: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i && !wb_ack_o))
    else $error("ack without request");
  chk_dat_idle: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
    else $error("read data outside ack");
  chk_flags_width: assert property (wb_ack_o |-> wb_dat_o[31:16] == 16'h0)
    else $error("upper read bits set");
  chk_trim_width: assert property (wb_ack_o && $past(wb_adr_i[13:2] >= 12'h310)
    |-> wb_dat_o[31:8] == 24'h0)
    else $error("trim read wider than a byte");
  chk_unmapped_zero: assert property (wb_ack_o && $past(wb_adr_i[13:2] < 12'h2c0)
    |-> wb_dat_o == 32'h0)
    else $error("unmapped read not zero");
  chk_idle_no_ack: assert property (!wb_cyc_i |=> !wb_ack_o)
    else $error("ack while idle");
endmodule // lane_alarm_trim_chk
bind lane_fifo_alarm_and_timing_trim_regs lane_alarm_trim_chk chk (.sys_clk(sys_clk),
  .rst_n(rst_n), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
  .wb_adr_i(wb_adr_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o));

// *** tb_lane_fifo_alarm_and_timing_trim_regs.sv ***
`timescale 1ns/1ns
`include "lane_alarm_trim_defines.vh"
`define CHK(nm, e, g) begin checked++; if ((g) !== (e)) begin miscompares++; \
  $display("[FAIL] %s expected %h seen %h", nm, e, g); end end
module tb_lane_fifo_alarm_and_timing_trim_regs;
  logic sys_clk = 0, rst_n = 0, cyc = 0, stb = 0, we = 0, ack, irq, globalAlarm;
  logic [13:0] adr = 0;
  logic [3:0] sel = 4'hf;
  logic [31:0] datI = 0, datO, q;
  logic [15:0] fault = 0;
  logic [7:0] coreATrim, coreBTrim;
  logic [7:0] fuse [5] = '{8'h11, 8'h22, 8'h33, 8'h44, 8'h55};
  logic [11:0] trimIdx [5] = '{12'h310, 12'h313, 12'h314, 12'h315, 12'h31a};
  int miscompares = 0, checked = 0;
  lane_fifo_alarm_and_timing_trim_regs dut (.sys_clk(sys_clk), .rst_n(rst_n), .wb_cyc_i(cyc),
    .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(datI),
    .wb_dat_o(datO), .wb_ack_o(ack), .laneFifoFault(fault), .fuseCoreADual(fuse[0]),
    .fuseCoreBDual(fuse[1]), .fuseCoreASingleIn1(fuse[2]), .fuseCoreBSingleIn1(fuse[3]),
    .fuseCoreASingleIn2(fuse[4]), .coreATrim(coreATrim), .coreBTrim(coreBTrim),
    .globalAlarm(globalAlarm), .irq(irq));
  initial forever #50 sys_clk = ~sys_clk;
  task automatic print_verdict;
    $display("comparisons %0d mismatches %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  // Read data is taken at the very edge that samples ack high
  task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge sys_clk);
    cyc <= 1;
    stb <= 1;
    we <= w;
    adr <= {a, 2'b00};
    datI <= d;
    do begin @(posedge sys_clk); n++; end while (ack !== 1'b1 && n < 20);
    q = datO;
    cyc <= 0;
    stb <= 0;
    we <= 0;
    if (n >= 20) begin miscompares++; print_verdict(); end
  endtask
  initial begin
    repeat (8) @(posedge sys_clk);
    rst_n <= 1;
    repeat (3) @(posedge sys_clk);
    bus(0, `IDX_LANE_FIFO_ERROR_FLAGS, 0); `CHK("laneFlags", 32'hffff, q)
    bus(0, `IDX_EVENT_STATUS, 0); `CHK("summary", 1'b1, q[5])
    `CHK("coreATrim", fuse[0], coreATrim)
    `CHK("coreBTrim", fuse[1], coreBTrim)
    for (int i = 0; i < 5; i++) begin bus(0, trimIdx[i], 0); `CHK("fuse", {24'h0, fuse[i]}, q) end
    for (int i = 0; i < 5; i++) begin bus(1, trimIdx[i], {24'h0, ~fuse[i]}); bus(0, trimIdx[i], 0);
      `CHK("trimRw", {24'h0, ~fuse[i]}, q) end
    repeat (2) @(posedge sys_clk);
    `CHK("coreATrim", ~fuse[0], coreATrim)
    bus(1, `IDX_MODE_CTRL, 32'h3);
    repeat (2) @(posedge sys_clk);
    `CHK("coreATrim", ~fuse[2], coreATrim)
    `CHK("coreBTrim", ~fuse[3], coreBTrim)
    bus(1, `IDX_MODE_CTRL, 32'h5);
    repeat (2) @(posedge sys_clk);
    `CHK("coreATrim", ~fuse[4], coreATrim)
    `CHK("coreBTrim", ~fuse[1], coreBTrim)
    // Single mode on input one without foreground cal falls back to the dual trims
    bus(1, `IDX_MODE_CTRL, 32'h1);
    repeat (2) @(posedge sys_clk);
    `CHK("coreATrim", ~fuse[0], coreATrim)
    `CHK("coreBTrim", ~fuse[1], coreBTrim)
    $display("test trims done");
    bus(1, `IDX_LANE_FIFO_ERROR_FLAGS, 32'h00ff); bus(0, `IDX_LANE_FIFO_ERROR_FLAGS, 0);
    `CHK("laneFlags", 32'hff00, q)
    bus(1, `IDX_EVENT_STATUS, 32'h20); bus(0, `IDX_LANE_FIFO_ERROR_FLAGS, 0);
    `CHK("laneFlags", 32'h0, q)
    bus(1, `IDX_IRQ_CLEAR, 32'h3);
    bus(1, `IDX_IRQ_ENABLE, 32'h1);
    bus(1, `IDX_EVENT_MASK, 32'h1f);
    `CHK("globalAlarm", 1'b0, globalAlarm)
    `CHK("irq", 1'b0, irq)
    fault <= 16'h0008;
    repeat (6) @(posedge sys_clk);
    bus(0, `IDX_LANE_FIFO_ERROR_FLAGS, 0); `CHK("laneFlags", 32'h8, q)
    bus(0, `IDX_EVENT_STATUS, 0); `CHK("summary", 1'b1, q[5])
    `CHK("globalAlarm", 1'b1, globalAlarm)
    `CHK("irq", 1'b1, irq)
    bus(1, `IDX_LANE_FIFO_ERROR_FLAGS, 32'h8); bus(0, `IDX_LANE_FIFO_ERROR_FLAGS, 0);
    `CHK("laneFlags", 32'h8, q)
    fault <= 16'h0;
    repeat (6) @(posedge sys_clk);
    bus(0, `IDX_LANE_FIFO_ERROR_FLAGS, 0); `CHK("laneFlags", 32'h8, q)
    // The irq flop follows an enable write one edge after ack
    bus(1, `IDX_IRQ_ENABLE, 32'h0);
    @(posedge sys_clk);
    `CHK("irqMasked", 1'b0, irq)
    bus(1, `IDX_IRQ_CLEAR, 32'h3);
    bus(1, `IDX_IRQ_ENABLE, 32'h1);
    @(posedge sys_clk);
    `CHK("irqCleared", 1'b0, irq)
    bus(0, 12'h000, 0); `CHK("unmapped", 32'h0, q)
    $display("test alarms done");
    print_verdict();
  end
endmodule // tb_lane_fifo_alarm_and_timing_trim_regs
